// ==== hw/channel_clock_divider.sv ====
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - four dividers, each drives its own group of three output clocks
// - output low for low count plus one, high for high count plus one
// - unbypassed ratio is high plus low plus two, range 2 to 32
// - bypass passes input at ratio one and stops the divider
// - counts run on the distribution input, prescaler or external clock
// - duty correction on by default, off per channel by its bit
// - correction off: high fraction is high plus one over ratio
// - bypass after prescaler 3 or 5: 33.3/40% uncorrected, 50% corrected
// - non-50% input after odd prescaler gives partial correction on odd
// - prescaler one with correction: even and 50%-input odd give 50%
// - prescaler bypassed: bypassed channel keeps input duty unchanged
// - direct oscillator gives 50%, direct external keeps its duty
// - prescaler ratios 1 to 6 from a 3-bit field
module channel_clock_divider (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        osc_in,
  input  wire logic        ext_clk_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [11:0] output_clocks
);

  // ************************************
  // helper functions
  // ************************************

  // reserved prescaler codes fold onto the nearest legal ratio
  function automatic logic [2:0] ratio_of(input logic [2:0] f);
    if (f == 3'h0)
      return 3'h1;
    if (f == 3'h7)
      return 3'h6;
    return f;
  endfunction

  // odd ratio when exactly one count is odd
  function automatic logic odd_ratio(input clkdiv_pkg::chan_cfg_t c);
    return c.low_cnt[0] ^ c.high_cnt[0];
  endfunction

  // ************************************
  // state
  // ************************************
  logic [7:0]          counts [clkdiv_pkg::NUM_CHAN];
  logic                byp    [clkdiv_pkg::NUM_CHAN];
  logic [1:0]          duty   [clkdiv_pkg::NUM_CHAN];
  logic [2:0]          presc_field;
  logic [1:0]          src_sel;
  clkdiv_pkg::chan_cfg_t cfg  [clkdiv_pkg::NUM_CHAN];
  logic [1:0]          pin_meta;
  logic [1:0]          pin_sync;
  logic                pin_prev;
  logic                pin_lvl;
  logic                pin_q;
  logic [2:0]          pc;
  logic [2:0]          ratio;
  logic [2:0]          half;
  logic                presc_off;
  logic                next_dist;
  logic                next_fix;
  logic                dist_q;
  logic                fix_q;
  logic                dist_prev;
  logic                d_rise;
  logic                d_fall;
  clkdiv_pkg::phase_t  phase  [clkdiv_pkg::NUM_CHAN];
  logic [3:0]          cnt    [clkdiv_pkg::NUM_CHAN];
  logic                hold   [clkdiv_pkg::NUM_CHAN];
  logic [3:0]          chan_lvl;
  logic [8:0]          idx;
  logic                aligned;
  logic                access;
  logic                hit;
  logic [7:0]          rdata;

  // ************************************
  // configuration view
  // ************************************

  // unpack register fields into per-channel config
  always_comb begin
    for (int i = 0; i < clkdiv_pkg::NUM_CHAN; i++) begin
      cfg[i].low_cnt  = counts[i][clkdiv_pkg::LOW_LSB +: 4];
      cfg[i].high_cnt = counts[i][clkdiv_pkg::HIGH_LSB +: 4];
      cfg[i].bypass   = byp[i];
      cfg[i].dcc_off  = duty[i][clkdiv_pkg::DCC_OFF_BIT];
      cfg[i].direct   = duty[i][clkdiv_pkg::DIRECT_BIT];
    end
  end

  // ************************************
  // pin synchronisers
  // ************************************

  // both clock pins are asynchronous, two flops before any use
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= {ext_clk_in, osc_in};
      pin_sync <= pin_meta;
    end
  end

  // source mux: oscillator or external input
  assign pin_lvl = (src_sel == clkdiv_pkg::SRC_OSC) ? pin_sync[0] : pin_sync[1];

  // ************************************
  // prescaler
  // ************************************
  assign ratio     = ratio_of(presc_field);
  assign half      = ratio >> 1;
  assign presc_off = (src_sel == clkdiv_pkg::SRC_EXT_DIRECT) || (ratio == 3'h1);

  // counts rising edges of the selected pin level
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev <= 1'b0;
      pc       <= 3'h0;
    end else begin
      pin_prev <= pin_lvl;
      if (pin_lvl && !pin_prev) begin
        if (pc >= ratio - 3'h1)
          pc <= 3'h0;
        else
          pc <= pc + 3'h1;
      end
    end
  end

  // raw output: odd ratios run short-high, even ones at 50%
  // corrected copy stretches odd highs to the input's fall; pin_prev is in step with pc
  always_comb begin
    if (presc_off) begin
      next_dist = pin_lvl;
      next_fix  = pin_lvl;
    end else begin
      next_dist = (pc < half);
      next_fix  = (pc < half) || (ratio[0] && (pc == half) && pin_prev);
    end
  end

  // distribution input and its edges, all channels see the same
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dist_q    <= 1'b0;
      fix_q     <= 1'b0;
      pin_q     <= 1'b0;
      dist_prev <= 1'b0;
    end else begin
      dist_q    <= next_dist;
      fix_q     <= next_fix;
      pin_q     <= pin_lvl;
      dist_prev <= dist_q;
    end
  end

  assign d_rise = dist_q && !dist_prev;
  assign d_fall = !dist_q && dist_prev;

  // ************************************
  // channel dividers
  // ************************************

  // phase counter reloads at each end of phase; bypass parks it
  // so the divider is effectively powered down
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < clkdiv_pkg::NUM_CHAN; i++) begin
        phase[i] <= clkdiv_pkg::PH_LOW;
        cnt[i]   <= 4'h0;
        hold[i]  <= 1'b0;
      end
    end else begin
      for (int i = 0; i < clkdiv_pkg::NUM_CHAN; i++) begin
        if (cfg[i].bypass) begin
          phase[i] <= clkdiv_pkg::PH_LOW;
          cnt[i]   <= 4'h0;
          hold[i]  <= 1'b0;
        end else if (d_rise) begin
          if (cnt[i] == 4'h0) begin
            if (phase[i] == clkdiv_pkg::PH_HIGH) begin
              phase[i] <= clkdiv_pkg::PH_LOW;
              cnt[i]   <= cfg[i].low_cnt;
              hold[i]  <= !cfg[i].dcc_off && odd_ratio(cfg[i]);
            end else begin
              phase[i] <= clkdiv_pkg::PH_HIGH;
              cnt[i]   <= cfg[i].high_cnt;
              hold[i]  <= 1'b0;
            end
          end else begin
            cnt[i] <= cnt[i] - 4'h1;
          end
        end else if (d_fall) begin
          hold[i] <= 1'b0;
        end
      end
    end
  end

  // output level per channel; correction only stretches highs,
  // so with a non-50% input odd ratios end up partially corrected
  always_comb begin
    for (int i = 0; i < clkdiv_pkg::NUM_CHAN; i++) begin
      if (cfg[i].direct)
        chan_lvl[i] = pin_q;
      else if (cfg[i].bypass)
        chan_lvl[i] = cfg[i].dcc_off ? dist_q : fix_q;
      else
        chan_lvl[i] = (phase[i] == clkdiv_pkg::PH_HIGH) || hold[i];
    end
  end

  // each channel fans out to its three drivers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      output_clocks <= 12'h000;
    else
      for (int i = 0; i < clkdiv_pkg::NUM_CHAN; i++)
        output_clocks[i*clkdiv_pkg::GROUP +: clkdiv_pkg::GROUP] <= {3{chan_lvl[i]}};
  end

  // ************************************
  // apb slave
  // ************************************
  assign idx     = paddr[10:2];
  assign aligned = !paddr[11] && (paddr[1:0] == 2'h0);
  assign access  = psel && penable && pready;

  // read mux and decode; status is read-only
  always_comb begin
    hit   = 1'b0;
    rdata = 8'h00;
    if (aligned) begin
      for (int i = 0; i < clkdiv_pkg::NUM_CHAN; i++) begin
        if (idx == clkdiv_pkg::CNT0_IDX + 9'(3*i)) begin
          hit   = 1'b1;
          rdata = counts[i];
        end
        if (idx == clkdiv_pkg::BYP0_IDX + 9'(3*i)) begin
          hit   = 1'b1;
          rdata = {byp[i], 7'h00};
        end
        if (idx == clkdiv_pkg::DUT0_IDX + 9'(3*i)) begin
          hit   = 1'b1;
          rdata = {6'h00, duty[i]};
        end
      end
      if (idx == clkdiv_pkg::PRESC_IDX) begin
        hit   = 1'b1;
        rdata = {5'h00, presc_field};
      end
      if (idx == clkdiv_pkg::SOURCE_IDX) begin
        hit   = 1'b1;
        rdata = {6'h00, src_sel};
      end
      if (idx == clkdiv_pkg::STATUS_IDX) begin
        hit   = !pwrite;
        rdata = {3'h0, dist_q, chan_lvl};
      end
    end
  end

  // register writes land only at the completing edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < clkdiv_pkg::NUM_CHAN; i++) begin
        counts[i] <= clkdiv_pkg::CNT_RST;
        byp[i]    <= 1'b0;
        duty[i]   <= 2'h0;
      end
      presc_field <= clkdiv_pkg::PRESC_RST;
      src_sel     <= clkdiv_pkg::SRC_RST;
    end else if (access && pwrite && aligned) begin
      for (int i = 0; i < clkdiv_pkg::NUM_CHAN; i++) begin
        if (idx == clkdiv_pkg::CNT0_IDX + 9'(3*i))
          counts[i] <= pwdata[7:0];
        if (idx == clkdiv_pkg::BYP0_IDX + 9'(3*i))
          byp[i] <= pwdata[clkdiv_pkg::BYPASS_BIT];
        if (idx == clkdiv_pkg::DUT0_IDX + 9'(3*i))
          duty[i] <= pwdata[1:0];
      end
      if (idx == clkdiv_pkg::PRESC_IDX)
        presc_field <= pwdata[2:0];
      if (idx == clkdiv_pkg::SOURCE_IDX)
        src_sel <= pwdata[1:0];
    end
  end

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && hit) ? {24'h00_0000, rdata} : 32'h0000_0000;
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  // ************************************
  // assertions
  // ************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_end_high;
    d_rise && !cfg[0].bypass && cnt[0] == 4'h0 && phase[0] == clkdiv_pkg::PH_HIGH;
  endsequence

  property p_low_load;
    s_end_high |=> phase[0] == clkdiv_pkg::PH_LOW && cnt[0] == $past(cfg[0].low_cnt);
  endproperty
  a_low_load: assert property (p_low_load) else $error("low phase load wrong");

  property p_high_load;
    d_rise && !cfg[0].bypass && cnt[0] == 4'h0 && phase[0] == clkdiv_pkg::PH_LOW
      |=> phase[0] == clkdiv_pkg::PH_HIGH && cnt[0] == $past(cfg[0].high_cnt);
  endproperty
  a_high_load: assert property (p_high_load) else $error("high phase load wrong");

  property p_count_down;
    d_rise && !cfg[0].bypass && cnt[0] != 4'h0 |=> cnt[0] == $past(cnt[0]) - 4'h1;
  endproperty
  a_count_down: assert property (p_count_down) else $error("count step wrong");

  property p_bypass_parked;
    cfg[1].bypass |=> cnt[1] == 4'h0 && !hold[1];
  endproperty
  a_bypass_parked: assert property (p_bypass_parked) else $error("bypass not parked");

  property p_hold_needs_odd;
    $rose(hold[2]) |-> $past(odd_ratio(cfg[2])) && !$past(cfg[2].dcc_off);
  endproperty
  a_hold_needs_odd: assert property (p_hold_needs_odd) else $error("stretch on bad ratio");

  property p_hold_ends;
    hold[2] && d_fall |=> !hold[2];
  endproperty
  a_hold_ends: assert property (p_hold_ends) else $error("stretch not ended");

  property p_group_equal;
    output_clocks[2:0] == {3{output_clocks[0]}} && output_clocks[11:9] == {3{output_clocks[9]}};
  endproperty
  a_group_equal: assert property (p_group_equal) else $error("group outputs differ");

  property p_direct;
    cfg[2].direct |=> output_clocks[6] == $past(pin_q);
  endproperty
  a_direct: assert property (p_direct) else $error("direct output mismatch");

  property p_presc_range;
    pc < ratio || $changed(presc_field) || $past(pin_lvl && !pin_prev) == 1'b0;
  endproperty
  a_presc_range: assert property (p_presc_range) else $error("prescaler count out of range");

  sequence s_access;
    psel && penable && !pready;
  endsequence

  property p_apb_answer;
    s_access |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");

endmodule // channel_clock_divider
`default_nettype wire

// ==== hw/clkdiv_pkg.sv ====
`default_nettype none
package clkdiv_pkg;

  // ************************************
  // register indices, byte address = 4 x index
  // ************************************
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned GROUP    = 3;
  localparam logic [8:0] CNT0_IDX = 9'h190;
  localparam logic [8:0] BYP0_IDX = 9'h191;
  localparam logic [8:0] DUT0_IDX = 9'h192;
  localparam logic [8:0] CNT1_IDX = 9'h193;
  localparam logic [8:0] BYP1_IDX = 9'h194;
  localparam logic [8:0] DUT1_IDX = 9'h195;
  localparam logic [8:0] CNT2_IDX = 9'h196;
  localparam logic [8:0] BYP2_IDX = 9'h197;
  localparam logic [8:0] DUT2_IDX = 9'h198;
  localparam logic [8:0] CNT3_IDX = 9'h199;
  localparam logic [8:0] BYP3_IDX = 9'h19A;
  localparam logic [8:0] DUT3_IDX = 9'h19B;
  localparam logic [8:0] PRESC_IDX  = 9'h1E0;
  localparam logic [8:0] SOURCE_IDX = 9'h1E1;
  localparam logic [8:0] STATUS_IDX = 9'h1E2;

  // ************************************
  // field positions
  // ************************************
  localparam int unsigned LOW_LSB    = 4;
  localparam int unsigned HIGH_LSB   = 0;
  localparam int unsigned BYPASS_BIT = 7;
  localparam int unsigned DCC_OFF_BIT = 0;
  localparam int unsigned DIRECT_BIT = 1;

  // ************************************
  // reset values and encodings
  // ************************************
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [2:0] PRESC_RST = 3'h2;
  localparam logic [1:0] SRC_RST   = 2'h2;
  localparam logic [1:0] SRC_EXT_DIRECT = 2'h1;
  localparam logic [1:0] SRC_OSC        = 2'h2;

  typedef enum logic {PH_LOW, PH_HIGH} phase_t;

  typedef struct packed {
    logic [3:0] low_cnt;
    logic [3:0] high_cnt;
    logic       bypass;
    logic       dcc_off;
    logic       direct;
  } chan_cfg_t;

endpackage
`default_nettype wire

// ==== testbench/clock_driver_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************
// output driver model: times each group
// ************************************
module clock_driver_model (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [11:0]      output_clocks,
  output logic      [3:0][15:0] hi_len,
  output logic      [3:0][15:0] lo_len,
  output logic                  group_split
);
  logic [3:0][15:0] run;
  logic [3:0]       prev;

  // phase timer per group in system clocks; only the last full phase is kept
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run    <= '0;
      prev   <= '0;
      hi_len <= '0;
      lo_len <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        prev[i] <= output_clocks[3*i];
        if (output_clocks[3*i] != prev[i]) begin
          run[i] <= 16'h0001;
          if (prev[i]) hi_len[i] <= run[i];
          else lo_len[i] <= run[i];
        end else begin
          run[i] <= run[i] + 16'h0001;
        end
      end
    end
  end

  // drivers of one group must agree; sticky so a one-cycle split is not lost
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) group_split <= 1'b0;
    else for (int i = 0; i < 4; i++)
      if (output_clocks[3*i+:3] != {3{output_clocks[3*i]}}) group_split <= 1'b1;
  end
endmodule // clock_driver_model
`default_nettype wire

// ==== testbench/tb_channel_clock_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_channel_clock_divider;
  logic             clock, reset_n, osc_in, ext_clk_in;
  logic             psel, penable, pwrite, pready, pslverr, group_split;
  logic [11:0]      paddr, output_clocks;
  logic [31:0]      pwdata, prdata;
  logic [3:0][15:0] hi_len, lo_len;
  logic [2:0]       ph;
  int               error_cnt, n_checks;

  channel_clock_divider u_channel_clock_divider (.clock(clock), .reset_n(reset_n),
    .osc_in(osc_in), .ext_clk_in(ext_clk_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .output_clocks(output_clocks));
  clock_driver_model u_clock_driver_model (.clock(clock), .reset_n(reset_n),
    .output_clocks(output_clocks), .hi_len(hi_len), .lo_len(lo_len),
    .group_split(group_split));

  // ************************************
  // clocks and pins
  // ************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // eight clocks per pin cycle so every pin phase lasts at least two clocks
  always @(posedge clock) begin
    ph <= ph + 3'h1;
    osc_in <= (ph < 3'h4);
    ext_clk_in <= (ph < 3'h2);
  end

  // ************************************
  // shared tasks
  // ************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [8:0] idx, input logic [1:0] lo,
                     input logic [7:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, idx, lo};
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    chk("apb wait", n, 32'h2);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, 2'h0, d, r, e);
    chk("write error", {31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [8:0] idx, input logic [7:0] exp, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 2'h0, 8'h00, r, e);
    chk(nm, r, {24'h000000, exp});
  endtask
  task automatic cfg(input int ch, input logic [3:0] m, input logic [3:0] n,
                     input logic byp, input logic off, input logic dir);
    wr(clkdiv_pkg::CNT0_IDX + 9'(3*ch), {m, n});
    wr(clkdiv_pkg::BYP0_IDX + 9'(3*ch), {byp, 7'h00});
    wr(clkdiv_pkg::DUT0_IDX + 9'(3*ch), {6'h00, dir, off});
  endtask
  task automatic meas(input int ch, input int hi, input int lo);
    chk("high phase", 32'(hi_len[ch]), 32'(hi));
    chk("low phase", 32'(lo_len[ch]), 32'(lo));
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_registers();
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 4; i++) begin
      rd(clkdiv_pkg::CNT0_IDX + 9'(3*i), 8'h00, "count reset");
      rd(clkdiv_pkg::BYP0_IDX + 9'(3*i), 8'h00, "bypass reset");
      rd(clkdiv_pkg::DUT0_IDX + 9'(3*i), 8'h00, "duty reset");
    end
    rd(clkdiv_pkg::PRESC_IDX, {5'h00, clkdiv_pkg::PRESC_RST}, "prescaler reset");
    rd(clkdiv_pkg::SOURCE_IDX, {6'h00, clkdiv_pkg::SRC_RST}, "source reset");
    wr(clkdiv_pkg::CNT2_IDX, 8'hA5);
    rd(clkdiv_pkg::CNT2_IDX, 8'hA5, "count readback");
    apb(1'b0, 9'h1FF, 2'h0, 8'h00, r, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    apb(1'b1, clkdiv_pkg::CNT0_IDX, 2'h1, 8'h33, r, e);
    chk("misaligned error", {31'h0, e}, 32'h1);
    apb(1'b1, clkdiv_pkg::STATUS_IDX, 2'h0, 8'hFF, r, e);
    chk("status write error", {31'h0, e}, 32'h1);
    rd(clkdiv_pkg::CNT0_IDX, 8'h00, "refused write");
  endtask
  // ratio 2, ratio 32, odd corrected and odd uncorrected, side by side
  task automatic t_divide(input int p);
    int n_t[4] = '{0, 15, 1, 3};
    int m_t[4] = '{0, 15, 2, 0};
    int odd;
    wr(clkdiv_pkg::SOURCE_IDX, {6'h00, clkdiv_pkg::SRC_OSC});
    wr(clkdiv_pkg::PRESC_IDX, 8'(p));
    for (int i = 0; i < 4; i++)
      cfg(i, 4'(m_t[i]), 4'(n_t[i]), 1'b0, 1'(i == 3), 1'b0);
    repeat (800 * p) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      odd = (i == 2) ? 4 * p : 0;
      meas(i, (n_t[i] + 1) * 8 * p + odd, (m_t[i] + 1) * 8 * p - odd);
    end
  endtask
  // prescaler set before bypass, so ratio one is never seen with a bypassed channel
  task automatic t_bypass(input int p, input int hoff, input int loff, input int hon,
                          input int lon);
    wr(clkdiv_pkg::PRESC_IDX, 8'(p));
    cfg(0, 4'h0, 4'h0, 1'b1, 1'b1, 1'b0);
    cfg(1, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0);
    repeat (100 * p) @(posedge clock);
    meas(0, hoff, loff);
    meas(1, hon, lon);
  endtask
  task automatic t_external();
    wr(clkdiv_pkg::SOURCE_IDX, {6'h00, clkdiv_pkg::SRC_EXT_DIRECT});
    cfg(3, 4'h2, 4'h1, 1'b0, 1'b0, 1'b0);
    repeat (200) @(posedge clock);
    meas(0, 2, 6);
    meas(1, 2, 6);
    meas(3, 18, 22);
    wr(clkdiv_pkg::SOURCE_IDX, 8'h00);
    cfg(2, 4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
    repeat (100) @(posedge clock);
    meas(2, 2, 6);
    wr(clkdiv_pkg::SOURCE_IDX, {6'h00, clkdiv_pkg::SRC_OSC});
    repeat (100) @(posedge clock);
    meas(2, 4, 4);
  endtask

  task automatic conclude();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, osc_in, ext_clk_in} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ph = 3'h0;
    error_cnt = 0;
    n_checks = 0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    t_registers();
    t_divide(1);
    t_divide(2);
    t_bypass(3, 8, 16, 12, 12);
    t_bypass(4, 16, 16, 16, 16);
    t_bypass(5, 16, 24, 20, 20);
    t_bypass(6, 24, 24, 24, 24);
    t_external();
    chk("group split", {31'h0, group_split}, 32'h0);
    conclude();
  end
  // watchdog: the run needs about 5000 clocks, so 20000 means a hang
  initial begin
    #1000000;
    error_cnt++;
    conclude();
  end
endmodule // tb_channel_clock_divider
`default_nettype wire
